// ### logic/dpr_ctl.sv
`timescale 1ns/1ps
// Behaviour
// - precharge encoding with all flag, bank
// - all-bank precharge recovery no shorter than single-bank
// - read to precharge spacing formula
// - read-to-precharge time starts at last prefetch
// - no precharge before activate-to-precharge time
// - precharge to activate waits row precharge
// - write to precharge spacing formula
// - device writes whole prefetch groups of eight
// - auto-precharge bit keeps or closes bank
// - read auto-precharge at later point
// - write auto-precharge after write recovery
// - activate after auto-precharge: precharge, cycle times
// - no same-bank access after auto-precharge
// - write auto-precharge to other-bank spacing
// - precharges one clock apart, latest counts
// - never issue inside minimum delays
// - refresh encoding, all-bank select bit
// - refresh only with all banks idle
// - refresh zeroes pointer, leaves banks idle
// - refresh waits refresh and precharge times
// - average interval, at most eight postponed
// - at most eight pulled in early
// - at most sixteen per two intervals
module dpr_ctl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // command bus
  dpr_ca_if.ctl            ca
);
  import dpr_pkg::*;
  typedef enum logic [1:0] {
    RF_IDLE = 2'h0,
    RF_PREA = 2'h1,
    RF_REF  = 2'h2
  } dpr_rf_e;
  typedef struct packed {
    logic           cs_n;
    logic [CAW-1:0] ca_r;
    logic [CAW-1:0] ca_f;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           pend;
    dpr_op_e        op;
    logic           bank;
    logic           ap;
    logic           ren;
    logic [1:0]     open;
    dpr_tmr_t [1:0] act_t;
    dpr_tmr_t [1:0] pre_t;
    dpr_tmr_t       rd_t;
    dpr_tmr_t       wr_t;
    dpr_tmr_t       ref_t;
    dpr_tmr_t       refi;
    dpr_debt_t      debt;
    dpr_rf_e        rf;
  } dpr_ctl_s;
  dpr_ctl_s r;
  dpr_ctl_s n;
  dpr_op_e  iop;
  logic     ib;
  logic     iap;
  logic     ok;
  logic     err;
  dpr_op_e  wop;
  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    n         = r;
    n.cs_n    = 1'b1;
    n.ca_r    = '0;
    n.ca_f    = '0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    wop       = dpr_op_e'(pwdata[F_OP +: 3]);
    for (int b = 0; b < 2; b++) begin
      if (r.act_t[b] != '0) begin
        n.act_t[b] = r.act_t[b] - 1'b1;
      end
      if (r.pre_t[b] != '0) begin
        n.pre_t[b] = r.pre_t[b] - 1'b1;
      end
    end
    if (r.rd_t != '0) begin
      n.rd_t = r.rd_t - 1'b1;
    end
    if (r.wr_t != '0) begin
      n.wr_t = r.wr_t - 1'b1;
    end
    if (r.ref_t != '0) begin
      n.ref_t = r.ref_t - 1'b1;
    end
    if (r.refi == '0) begin
      n.refi = T_REFI - 1'b1;
      if (r.debt < DEBT_MAX) begin
        n.debt = r.debt + 5'sh01;
      end
    end else begin
      n.refi = r.refi - 1'b1;
    end
    // refresh sequencer: idle banks first, then refresh
    if (r.rf == RF_IDLE && r.ren &&
        (r.debt >= DEBT_MAX || (r.debt > 5'sh00 && !r.pend))) begin
      n.rf = (r.open != 2'h0) ? RF_PREA : RF_REF;
    end
    // pick the command: refresh owed in full preempts software
    iop = OP_NOP;
    ib  = r.bank;
    iap = r.ap;
    case (r.rf)
      RF_PREA: iop = OP_PREA;
      RF_REF:  iop = OP_REF;
      default: iop = r.pend ? r.op : OP_NOP;
    endcase
    // hold until the countdowns that gate this command are spent
    case (iop)
      OP_ACT:  ok = !r.open[ib] && r.act_t[ib] == '0 && r.ref_t == '0;
      OP_RD:   ok = r.open[ib] && r.rd_t == '0;
      OP_WR:   ok = r.open[ib] && r.wr_t == '0;
      OP_PRE:  ok = r.pre_t[ib] == '0;
      OP_PREA: ok = r.pre_t[0] == '0 && r.pre_t[1] == '0;
      // all idle, precharge and refresh done
      OP_REF:  ok = r.open == 2'h0 && r.act_t[0] == '0 &&
                    r.act_t[1] == '0 && r.ref_t == '0;
      default: ok = 1'b0;
    endcase
    if (ok) begin
      n.cs_n = 1'b0;
      case (iop)
        OP_ACT: begin
          n.ca_r[1:0]    = ENC_ACT;
          n.ca_r[CA_BA0] = ib;
          n.open[ib]     = 1'b1;
          n.pre_t[ib]    = tmax(n.pre_t[ib], T_RAS);
          n.act_t[ib]    = tmax(n.act_t[ib], T_RC);
        end
        OP_RD: begin
          n.ca_r[1:0]    = ENC_RW;
          n.ca_r[CA_RD]  = 1'b1;
          n.ca_r[CA_BA0] = ib;
          n.ca_f[CA_AP]  = iap;
          n.pre_t[ib]    = tmax(n.pre_t[ib], T_RD2PRE);
          n.rd_t         = tmax(n.rd_t, T_CCD);
          n.wr_t         = tmax(n.wr_t, T_RD2WR);
          if (iap) begin
            n.open[ib]  = 1'b0;
            n.act_t[ib] = tmax(n.act_t[ib], T_RD_AP + T_RPPB);
          end
        end
        OP_WR: begin
          n.ca_r[1:0]    = ENC_RW;
          n.ca_r[CA_BA0] = ib;
          n.ca_f[CA_AP]  = iap;
          n.pre_t[ib]    = tmax(n.pre_t[ib], T_WR2PRE);
          n.wr_t         = tmax(n.wr_t, T_CCD);
          n.rd_t         = tmax(n.rd_t, T_WR2RD);
          if (iap) begin
            n.open[ib]  = 1'b0;
            n.act_t[ib] = tmax(n.act_t[ib], T_WR_AP + T_RPPB);
          end
        end
        OP_PRE: begin
          n.ca_r[3:0]    = ENC_PRE;
          n.ca_r[CA_BA0] = ib;
          n.open[ib]     = 1'b0;
          n.act_t[ib]    = tmax(n.act_t[ib], T_RPPB);
        end
        OP_PREA: begin
          n.ca_r[3:0]   = ENC_PRE;
          n.ca_r[CA_AB] = 1'b1;
          n.open        = 2'h0;
          for (int b = 0; b < 2; b++) begin
            n.act_t[b] = tmax(n.act_t[b], T_RPAB);
          end
        end
        default: begin
          n.ca_r[2:0]    = ENC_REF;
          n.ca_r[CA_ALL] = 1'b1;
          // longer of refresh time and rate cap
          n.ref_t        = tmax(T_RFC, T_REF2REF);
          n.debt         = n.debt - 5'sh01;
        end
      endcase
      case (r.rf)
        RF_PREA: n.rf = RF_REF;
        RF_REF:  n.rf = RF_IDLE;
        default: n.pend = 1'b0;
      endcase
    end
    // -------------------------------------------------------------
    // apb registers
    // -------------------------------------------------------------
    // pull-in refused past eight ahead
    case (paddr)
      ADDR_CMD:  err = pwrite && (r.pend || wop > OP_REF ||
                       (wop == OP_REF && r.debt <= DEBT_MIN));
      ADDR_STAT: err = pwrite;
      ADDR_CTRL: err = 1'b0;
      default:   err = 1'b1;
    endcase
    if (psel && !penable) begin
      n.pready  = 1'b1;
      n.pslverr = err;
      case (paddr)
        ADDR_CMD:  n.prdata = {27'h0, r.ap, r.bank, r.op};
        ADDR_STAT: n.prdata = {23'h0, r.rf != RF_IDLE, r.debt,
                               r.open, r.pend};
        ADDR_CTRL: n.prdata = {31'h0, r.ren};
        default:   n.prdata = 32'h0;
      endcase
    end
    // write takes effect only on the completing edge; a stale
    // pull-in check is redone here so credit never overruns
    if (psel && penable && r.pready && pwrite && !r.pslverr &&
        !err) begin
      if (paddr == ADDR_CMD) begin
        n.pend = 1'b1;
        n.op   = wop;
        n.bank = pwdata[F_BANK];
        n.ap   = pwdata[F_AP];
      end else if (paddr == ADDR_CTRL) begin
        n.ren = pwdata[0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r      <= '0;
      r.cs_n <= 1'b1;
      r.refi <= T_REFI - 1'b1;
      r.ren  <= 1'b1;
    end else begin
      r <= n;
    end
  end
  assign ca.cs_n = r.cs_n;
  assign ca.ca_r = r.ca_r;
  assign ca.ca_f = r.ca_f;
  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
endmodule : dpr_ctl

// ### pkg/dpr_pkg.sv
package dpr_pkg;
  // -------------------------------------------------------------
  // clock and analog timings (ns), plain defaults
  // -------------------------------------------------------------
  localparam int TCK_NS   = 50;
  localparam int TRTP_NS  = 8;
  localparam int TWR_NS   = 15;
  localparam int TWTR_NS  = 8;
  localparam int TRPPB_NS = 18;
  localparam int TRPAB_NS = 21;
  localparam int TRAS_NS  = 42;
  localparam int TRC_NS   = 60;
  localparam int TRFC_NS  = 130;
  localparam int TREFI_NS = 7800;
  localparam int BL       = 8;
  localparam int WL       = 6;
  localparam int RL       = 10;

  function automatic int ru(input int t);
    int c;
    c = (t + TCK_NS - 1) / TCK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ru

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  // -------------------------------------------------------------
  // cycle counts
  // -------------------------------------------------------------
  localparam int TW = 8;
  typedef logic [TW-1:0] dpr_tmr_t;

  localparam int C_RTP = ru(TRTP_NS);
  localparam int C_WR  = ru(TWR_NS);
  localparam int C_WTR = ru(TWTR_NS);

  localparam dpr_tmr_t T_CCD    = dpr_tmr_t'(BL / 2);
  localparam dpr_tmr_t T_RPPB   = dpr_tmr_t'(ru(TRPPB_NS));
  localparam dpr_tmr_t T_RPAB   = dpr_tmr_t'(imax(ru(TRPAB_NS),
                                              ru(TRPPB_NS)));
  localparam dpr_tmr_t T_RAS    = dpr_tmr_t'(ru(TRAS_NS));
  localparam dpr_tmr_t T_RC     = dpr_tmr_t'(ru(TRC_NS));
  localparam dpr_tmr_t T_RFC    = dpr_tmr_t'(ru(TRFC_NS));
  localparam dpr_tmr_t T_REFI   = dpr_tmr_t'(TREFI_NS / TCK_NS);
  localparam dpr_tmr_t T_RD2PRE = dpr_tmr_t'(BL/2 + imax(4, C_RTP) - 4);
  localparam dpr_tmr_t T_RD_AP  = dpr_tmr_t'(imax(BL/2, BL/2 - 4 + C_RTP));
  localparam dpr_tmr_t T_WR_DONE = dpr_tmr_t'(WL + BL/2 + 1);
  localparam dpr_tmr_t T_WR_AP  = dpr_tmr_t'(WL + BL/2 + 1 + C_WR);
  localparam dpr_tmr_t T_WR2PRE = dpr_tmr_t'(WL + BL/2 + C_WR + 1);
  localparam dpr_tmr_t T_WR2RD  = dpr_tmr_t'(WL + BL/2 + C_WTR + 1);
  localparam dpr_tmr_t T_RD2WR  = dpr_tmr_t'(RL + BL/2 + 1 - WL);
  // refresh spacing that keeps sixteen within two intervals
  localparam dpr_tmr_t T_REF2REF =
    dpr_tmr_t'((2 * TREFI_NS / TCK_NS + 15) / 16);

  function automatic dpr_tmr_t tmax(input dpr_tmr_t a, input dpr_tmr_t b);
    return (a > b) ? a : b;
  endfunction : tmax

  // -------------------------------------------------------------
  // command/address bus layout
  // -------------------------------------------------------------
  localparam int CAW    = 10;
  localparam int CA_AP  = 0;
  localparam int CA_RD  = 2;
  localparam int CA_ALL = 3;
  localparam int CA_AB  = 4;
  localparam int CA_BA0 = 7;
  localparam logic [1:0] ENC_ACT = 2'h2;
  localparam logic [1:0] ENC_RW  = 2'h1;
  localparam logic [3:0] ENC_PRE = 4'hB;
  localparam logic [2:0] ENC_REF = 3'h4;

  typedef enum logic [2:0] {
    OP_NOP  = 3'h0,
    OP_ACT  = 3'h1,
    OP_RD   = 3'h2,
    OP_WR   = 3'h3,
    OP_PRE  = 3'h4,
    OP_PREA = 3'h5,
    OP_REF  = 3'h6
  } dpr_op_e;

  // -------------------------------------------------------------
  // refresh credit and registers
  // -------------------------------------------------------------
  typedef logic signed [4:0] dpr_debt_t;
  localparam dpr_debt_t DEBT_MAX = 5'sh08;
  localparam dpr_debt_t DEBT_MIN = -5'sh08;

  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam int F_OP   = 0;
  localparam int F_BANK = 3;
  localparam int F_AP   = 4;
endpackage : dpr_pkg

// ### pkg/dpr_ca_if.sv
`timescale 1ns/1ps
interface dpr_ca_if (
  input logic pclk,
  input logic presetn
);
  import dpr_pkg::*;
  logic           cs_n;
  logic [CAW-1:0] ca_r;
  logic [CAW-1:0] ca_f;

  modport dev (input pclk, input presetn, input cs_n,
               input ca_r, input ca_f);
  modport ctl (input pclk, input presetn, output cs_n,
               output ca_r, output ca_f);
endinterface : dpr_ca_if

// ### logic/dpr_dev.sv
`timescale 1ns/1ps
module dpr_dev (
  // command bus
  dpr_ca_if.dev ca,
  // bank status
  output logic [1:0] bank_open,
  output logic [1:0] bank_ready,
  output logic [1:0] ap_pending,
  output logic       ref_busy,
  output logic       bank_ptr
);
  import dpr_pkg::*;

  typedef struct packed {
    logic [1:0]     open;
    logic [1:0]     rdy;
    dpr_tmr_t [1:0] rp;
    dpr_tmr_t [1:0] ap;
    logic [1:0]     ap_on;
    dpr_tmr_t       rfc;
    logic           ptr;
  } dpr_dev_s;

  dpr_dev_s r;
  dpr_dev_s n;
  logic     bk;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    n  = r;
    bk = ca.ca_r[CA_BA0];
    if (r.rfc != '0) begin
      n.rfc = r.rfc - 1'b1;
    end
    for (int b = 0; b < 2; b++) begin
      if (r.rp[b] != '0) begin
        n.rp[b] = r.rp[b] - 1'b1;
      end
      if (r.ap_on[b]) begin
        if (r.ap[b] <= 8'h01) begin
          n.ap_on[b] = 1'b0;
          n.open[b]  = 1'b0;
          n.rp[b]    = T_RPPB;
        end else begin
          n.ap[b] = r.ap[b] - 1'b1;
        end
      end
    end
    if (!ca.cs_n) begin
      if (ca.ca_r[1:0] == ENC_ACT) begin
        n.open[bk] = 1'b1;
        // pointer tracks the last bank opened
        n.ptr      = bk;
      end else if (ca.ca_r[1:0] == ENC_RW) begin
        // ap bit picks open or auto close
        if (ca.ca_f[CA_AP]) begin
          n.ap_on[bk] = 1'b1;
          if (ca.ca_r[CA_RD]) begin
            // later of the two read points
            n.ap[bk] = T_RD_AP;
          end else begin
            n.ap[bk] = T_WR_DONE + dpr_tmr_t'(C_WR);
          end
        end
      end else if (ca.ca_r[3:0] == ENC_PRE) begin
        // all-bank recovery is the longer one
        if (ca.ca_r[CA_AB]) begin
          n.open  = 2'h0;
          n.ap_on = 2'h0;
          n.rp    = {T_RPAB, T_RPAB};
        end else begin
          n.open[bk]  = 1'b0;
          n.ap_on[bk] = 1'b0;
          n.rp[bk]    = T_RPPB;
        end
      end else if (ca.ca_r[2:0] == ENC_REF && ca.ca_r[CA_ALL]) begin
        // pointer to zero, banks idle after
        n.ptr   = 1'b0;
        n.rfc   = T_RFC;
        n.open  = 2'h0;
        n.ap_on = 2'h0;
      end
    end
    for (int b = 0; b < 2; b++) begin
      n.rdy[b] = !n.open[b] && n.rp[b] == '0 && n.rfc == '0;
    end
  end

  always_ff @(posedge ca.pclk or negedge ca.presetn) begin
    if (!ca.presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign bank_open  = r.open;
  assign bank_ready = r.rdy;
  assign ap_pending = r.ap_on;
  assign ref_busy   = (r.rfc != '0);
  assign bank_ptr   = r.ptr;
endmodule : dpr_dev

// ### testbench/dpr_asserts.sv
`timescale 1ns/1ps
module dpr_asserts (
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // command bus
  input wire logic                    cs_n,
  input wire logic [dpr_pkg::CAW-1:0] ca_r,
  input wire logic [dpr_pkg::CAW-1:0] ca_f,
  // device status
  input wire logic [1:0]              bank_open,
  input wire logic [1:0]              ap_pending,
  input wire logic                    ref_busy,
  input wire logic                    bank_ptr
);
  import dpr_pkg::*;
  localparam int RA_LO = int'(T_RD_AP) - 2;
  localparam int RA_HI = int'(T_RD_AP);
  localparam int WA_LO = int'(T_WR_AP) - 9;
  localparam int WA_HI = int'(T_WR_AP) - 7;
  // ----------------------------------------
  // decode, per-bank age counters and refresh age counter
  // ----------------------------------------
  logic [1:0] act_hit, rd_hit, wr_hit, pre_hit;
  logic [1:0] rd_bad, wr_bad, ras_bad;
  logic       ref_hit;
  dpr_tmr_t   since_rd [2];
  dpr_tmr_t   since_wr [2];
  dpr_tmr_t   since_act [2];
  dpr_tmr_t   since_ref;

  // saturate so an old command never wraps back into a window
  function automatic dpr_tmr_t age(input logic hit, input dpr_tmr_t c);
    return hit ? 8'h01 : ((c == 8'hFF) ? c : c + 8'h01);
  endfunction : age

  always_comb begin
    for (int b = 0; b < 2; b++) begin
      act_hit[b] = !cs_n && ca_r[1:0] == ENC_ACT && ca_r[CA_BA0] == 1'(b);
      rd_hit[b]  = !cs_n && ca_r[1:0] == ENC_RW && ca_r[CA_RD]
                   && ca_r[CA_BA0] == 1'(b);
      wr_hit[b]  = !cs_n && ca_r[1:0] == ENC_RW && !ca_r[CA_RD]
                   && ca_r[CA_BA0] == 1'(b);
      pre_hit[b] = !cs_n && ca_r[3:0] == ENC_PRE
                   && (ca_r[CA_AB] || ca_r[CA_BA0] == 1'(b));
      rd_bad[b]  = pre_hit[b] && since_rd[b] < T_RD2PRE;
      wr_bad[b]  = pre_hit[b] && since_wr[b] < T_WR2PRE;
      ras_bad[b] = pre_hit[b] && bank_open[b] && since_act[b] < T_RAS;
    end
    ref_hit = !cs_n && ca_r[2:0] == ENC_REF && ca_r[CA_ALL];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < 2; b++) begin
        since_rd[b]  <= 8'hFF;
        since_wr[b]  <= 8'hFF;
        since_act[b] <= 8'hFF;
      end
      since_ref <= 8'hFF;
    end else begin
      for (int b = 0; b < 2; b++) begin
        since_rd[b]  <= age(rd_hit[b], since_rd[b]);
        since_wr[b]  <= age(wr_hit[b], since_wr[b]);
        since_act[b] <= age(act_hit[b], since_act[b]);
      end
      since_ref <= age(ref_hit, since_ref);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_rd2pre;
    @(posedge pclk) disable iff (!presetn) |pre_hit |-> rd_bad == 2'b00;
  endproperty
  a_rd2pre: assert property (p_rd2pre)
    else $error("precharge too soon after read");
  property p_wr2pre;
    @(posedge pclk) disable iff (!presetn) |pre_hit |-> wr_bad == 2'b00;
  endproperty
  a_wr2pre: assert property (p_wr2pre)
    else $error("precharge too soon after write");
  property p_ras;
    @(posedge pclk) disable iff (!presetn) |pre_hit |-> ras_bad == 2'b00;
  endproperty
  a_ras: assert property (p_ras)
    else $error("precharge too soon after activate");
  property p_ref2act;
    @(posedge pclk) disable iff (!presetn) |act_hit |-> since_ref >= T_RFC;
  endproperty
  a_ref2act: assert property (p_ref2act)
    else $error("activate too soon after refresh");
  property p_ref_idle;
    @(posedge pclk) disable iff (!presetn) ref_hit |-> bank_open == 2'b00;
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("refresh with a bank open");
  property p_ref_ptr;
    @(posedge pclk) disable iff (!presetn) ref_hit |=> !bank_ptr && ref_busy;
  endproperty
  a_ref_ptr: assert property (p_ref_ptr)
    else $error("refresh left pointer or busy wrong");
  property p_ref_rate;
    @(posedge pclk) disable iff (!presetn) ref_hit |-> since_ref >= T_REF2REF;
  endproperty
  a_ref_rate: assert property (p_ref_rate)
    else $error("refresh too soon after refresh");
  property p_rdap;
    @(posedge pclk) disable iff (!presetn) rd_hit[0] && ca_f[CA_AP]
      |=> ap_pending[0] ##[RA_LO:RA_HI] !bank_open[0];
  endproperty
  a_rdap: assert property (p_rdap)
    else $error("read auto-precharge at wrong time");
  property p_wrap;
    @(posedge pclk) disable iff (!presetn) wr_hit[0] && ca_f[CA_AP]
      |=> bank_open[0] [*8] ##[WA_LO:WA_HI] !bank_open[0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("write auto-precharge at wrong time");
endmodule : dpr_asserts

// ### testbench/dpr_bench.sv
`timescale 1ns/1ps
module dpr_bench;
  import dpr_pkg::*;
  typedef struct {
    int         cyc;
    logic [9:0] r;
    logic       f;
  } dpr_cmd_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ref_busy, bank_ptr;
  logic [1:0]  bank_open, bank_ready, ap_pending;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          last_ref = -1;
  dpr_cmd_s    log [$];

  always #25 pclk = ~pclk;

  dpr_ca_if i_dpr_ca_if (.pclk(pclk), .presetn(presetn));
  dpr_ctl i_dpr_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ca(i_dpr_ca_if));
  dpr_dev i_dpr_dev (.ca(i_dpr_ca_if), .bank_open(bank_open),
    .bank_ready(bank_ready), .ap_pending(ap_pending), .ref_busy(ref_busy),
    .bank_ptr(bank_ptr));
  dpr_asserts i_dpr_asserts (.pclk(pclk), .presetn(presetn),
    .cs_n(i_dpr_ca_if.cs_n), .ca_r(i_dpr_ca_if.ca_r),
    .ca_f(i_dpr_ca_if.ca_f), .bank_open(bank_open),
    .ap_pending(ap_pending), .ref_busy(ref_busy), .bank_ptr(bank_ptr));
  // ----------------------------------------
  // command log and helpers
  // ----------------------------------------
  always @(posedge pclk) begin
    if (i_dpr_ca_if.cs_n === 1'b0) begin
      log.push_back('{cyc, i_dpr_ca_if.ca_r, i_dpr_ca_if.ca_f[0]});
      if (i_dpr_ca_if.ca_r[1:0] === 2'b00) last_ref = log.size() - 1;
    end
    cyc++;
  end

  function automatic int gap(input int a, input int b);
    return log[b].cyc - log[a].cyc;
  endfunction : gap

  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic fail(input string m);
    error_cnt++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("got %h exp %h", got, exp));
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) fail($sformatf("spacing %0d", got));
  endtask : chk_rng

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail("no pready");
      stop_test();
    end
  endtask : apb

  // a refused write means the previous command still waits its spacing
  task automatic cmd(input dpr_op_e op, input logic b, input logic ap);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b1, ADDR_CMD, {27'h0, ap, b, op}, q, e);
      n++;
    end while (e !== 1'b0 && n < 40);
    if (e !== 1'b0) begin
      fail("command refused");
      stop_test();
    end
  endtask : cmd

  task automatic wait_idle();
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STAT, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    if (q[0] !== 1'b0) begin
      fail("command never issued");
      stop_test();
    end
  endtask : wait_idle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    chk(q, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, ADDR_STAT, 32'hFF, q, e);
    chk(32'(e), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0, q, e);
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    chk(q, 32'h0);
  endtask : t_regs

  task automatic t_pre();
    int n;
    n = log.size();
    cmd(OP_ACT, 1'b0, 1'b0);
    cmd(OP_RD, 1'b0, 1'b0);
    cmd(OP_PRE, 1'b0, 1'b0);
    cmd(OP_ACT, 1'b1, 1'b0);
    cmd(OP_WR, 1'b1, 1'b0);
    cmd(OP_PREA, 1'b0, 1'b0);
    wait_idle();
    chk(32'(log[n+2].r), 32'h00B);
    chk(32'(log[n+5].r[4:0]), 32'h1B);
    chk_rng(gap(n, n+2), T_RAS, 999);
    chk_rng(gap(n+1, n+2), T_RD2PRE, 999);
    chk_rng(gap(n+4, n+5), T_WR2PRE, T_WR2PRE + 2);
    repeat (2) @(posedge pclk);
    chk(32'(bank_ready), 32'h3);
  endtask : t_pre

  task automatic t_ap();
    int n;
    n = log.size();
    cmd(OP_ACT, 1'b0, 1'b0);
    cmd(OP_RD, 1'b0, 1'b1);
    cmd(OP_ACT, 1'b0, 1'b0);
    cmd(OP_ACT, 1'b1, 1'b0);
    cmd(OP_WR, 1'b0, 1'b1);
    cmd(OP_RD, 1'b1, 1'b0);
    cmd(OP_ACT, 1'b0, 1'b0);
    cmd(OP_PREA, 1'b0, 1'b0);
    wait_idle();
    chk(32'(log[n+1].f), 32'h1);
    chk(32'(log[n+5].f), 32'h0);
    chk_rng(gap(n+1, n+2), T_RD_AP + T_RPPB, 999);
    chk_rng(gap(n, n+2), T_RC, 999);
    chk_rng(gap(n+4, n+5), T_WR2RD, T_WR2RD + 2);
    chk_rng(gap(n+4, n+6), T_WR_AP + T_RPPB, 999);
  endtask : t_ap

  task automatic t_ref();
    logic [31:0] q;
    logic        e;
    int          n;
    int          k;
    int          t;
    n = log.size();
    k = 0;
    do begin
      apb(1'b1, ADDR_CMD, 32'(OP_REF), q, e);
      if (e === 1'b0) wait_idle();
      k++;
    end while (e === 1'b0 && k < 20);
    apb(1'b0, ADDR_STAT, 32'h0, q, e);
    chk(32'(q[7:3]), 32'h18);
    chk_rng(k - 1, 8, 16);
    chk(32'(log[n].r[3:0]), 32'hC);
    chk_rng(gap(n, n+1), T_RFC, 999);
    t = log[log.size()-1].cyc;
    cmd(OP_ACT, 1'b1, 1'b0);
    wait_idle();
    chk_rng(gap(log.size()-2, log.size()-1), T_RFC, 999);
    chk(32'(bank_ptr), 32'h1);
    n = last_ref;
    apb(1'b1, ADDR_CTRL, 32'h1, q, e);
    k = 0;
    while (last_ref == n && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (last_ref == n) begin
      fail("no automatic refresh");
      stop_test();
    end
    repeat (2) @(posedge pclk);
    chk(32'(bank_ptr), 32'h0);
    chk(32'(log[last_ref-1].r[4:0]), 32'h1B);
    chk_rng(log[last_ref].cyc - t, 8 * T_REFI, 9 * T_REFI);
  endtask : t_ref

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pre();
    t_ap();
    t_ref();
    stop_test();
  end
endmodule : dpr_bench
